// >>> verilog/decode_pkg.sv
// package: encodings, phases and carriers for the branch/move/bank decoder
package decode_pkg;
  localparam logic [3:0] BRANCH_TOP = 4'hE;
  localparam logic [3:0] BRANCH_NO_OVERFLOW_OP_SUB = 4'h5;
  localparam logic [3:0] BNZ_SUB = 4'h1;
  localparam logic [3:0] MOVE_FIRST = 4'hC;
  localparam logic [3:0] MOVE_SECOND = 4'hF;
  localparam logic [7:0] BANK_LOAD_BYTE = 8'h01;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [1:0] Q_RESET = 2'h0;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [20:0] PC_STEP = 21'h000002;

  typedef enum {
    ST_FETCH,
    ST_BRANCH_NOP,
    ST_MOVE_SECOND
  } state_type;

  typedef struct packed {
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mem_req_type;
endpackage

// >>> verilog/quarter_phase.sv
// quarter-phase counter dividing each instruction cycle into four steps
`timescale 1ns/1ns
module quarter_phase
  import decode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  output logic [1:0] q,
  output logic q_end
);
  logic [1:0] next_q;

  always_comb begin
    next_q = q + 2'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= Q_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign q_end = (q == Q_LAST);
endmodule

// >>> verilog/branch_move_decoder.sv
// decoder and sequencer for branch, memory move and bank-select load
`timescale 1ns/1ns
// Contract
// - With overflow clear the no-overflow branch loads PC with fetch address plus 2 plus 2n.
// - The no-overflow branch is one word 1110 0101 with a signed 8-bit offset.
// - A branch takes one cycle untaken and two taken, PC written in Q4, extra cycle idle.
// - The nonzero branch, 1110 0001 plus offset, redirects only while zero is clear.
// - The move reads source in cycle one, no read in cycle two, writes dest in its Q4.
// - The move is word 1100 with a 12-bit source then word 1111 with a 12-bit dest.
// - The move copies the source byte unchanged and leaves the source intact.
// - The bank load, byte 0000 0001 plus literal, writes the bank register in one cycle.
module branch_move_decoder
  import decode_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // instruction fetch
  input wire logic [15:0] INSTR,
  // status flags from the alu
  input wire logic OVERFLOW,
  input wire logic ZERO,
  // data memory
  input wire logic [7:0] MEM_RDATA,
  output mem_req_type MEM,
  // core state
  output logic [20:0] PC,
  output logic [7:0] BANK_SELECT,
  output logic [1:0] QPHASE,
  output logic BUSY
);
  logic [1:0] q;
  logic q_end;
  state_type state, next_state;
  logic [20:0] pc, next_pc;
  logic [7:0] bank, next_bank;
  logic [7:0] move_data, next_move_data;
  mem_req_type mem, next_mem;
  logic [20:0] offset;
  logic is_move_first;
  logic is_move_second;
  logic is_bank_load;
  logic is_no_overflow;
  logic is_nonzero;
  logic branch_taken;
  logic next_busy;
  logic [1:0] next_qphase;

  // -----------------------------------------------------------------
  // quarter phase of the instruction cycle
  // -----------------------------------------------------------------
  quarter_phase u_phase (
    .clk(CLK),
    .rst_n(RST_N),
    .q(q),
    .q_end(q_end)
  );

  // -----------------------------------------------------------------
  // instruction decode
  // -----------------------------------------------------------------
  always_comb begin
    is_move_first = (INSTR[15:12] == MOVE_FIRST);
    is_move_second = (INSTR[15:12] == MOVE_SECOND);
    is_bank_load = (INSTR[15:8] == BANK_LOAD_BYTE);
    is_no_overflow = (INSTR[15:12] == BRANCH_TOP) && (INSTR[11:8] == BRANCH_NO_OVERFLOW_OP_SUB);
    is_nonzero = (INSTR[15:12] == BRANCH_TOP) && (INSTR[11:8] == BNZ_SUB);
    // flags only matter at the last quarter, when the decision is taken
    branch_taken = (is_no_overflow && !OVERFLOW) ||
                   (is_nonzero && !ZERO);
    // signed offset, doubled, sign-extended to the counter width
    offset = {{12{INSTR[7]}}, INSTR[7:0], 1'b0};
  end

  // -----------------------------------------------------------------
  // cycle sequencer
  // -----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_FETCH: begin
        if (q_end && is_move_first) begin
          next_state = ST_MOVE_SECOND;
        end else if (q_end && branch_taken) begin
          next_state = ST_BRANCH_NOP;
        end
      end
      ST_BRANCH_NOP: begin
        // idle cycle: the word on the fetch path is ignored
        if (q_end) begin
          next_state = ST_FETCH;
        end
      end
      ST_MOVE_SECOND: begin
        if (q_end) begin
          next_state = ST_FETCH;
        end
      end
      default: begin
        next_state = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= ST_FETCH;
    end else begin
      state <= next_state;
    end
  end

  // -----------------------------------------------------------------
  // program counter
  // -----------------------------------------------------------------
  always_comb begin
    next_pc = pc;
    if (q_end) begin
      case (state)
        ST_FETCH: begin
          if (branch_taken) begin
            next_pc = pc + PC_STEP + offset;
          end else begin
            next_pc = pc + PC_STEP;
          end
        end
        ST_MOVE_SECOND: begin
          next_pc = pc + PC_STEP;
        end
        default: begin
          // extra branch cycle leaves the counter alone
          next_pc = pc;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // -----------------------------------------------------------------
  // bank-select register
  // -----------------------------------------------------------------
  always_comb begin
    next_bank = bank;
    if (state == ST_FETCH && q_end && is_bank_load) begin
      // full literal kept, only the low nibble is meaningful
      next_bank = INSTR[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bank <= BANK_RESET;
    end else begin
      bank <= next_bank;
    end
  end

  // -----------------------------------------------------------------
  // move data holding register
  // -----------------------------------------------------------------
  always_comb begin
    next_move_data = move_data;
    if (state == ST_FETCH && is_move_first && q == 2'h2) begin
      next_move_data = MEM_RDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      move_data <= 8'h00;
    end else begin
      move_data <= next_move_data;
    end
  end

  // -----------------------------------------------------------------
  // data memory requests
  // -----------------------------------------------------------------
  always_comb begin
    next_mem = '0;
    if (state == ST_FETCH && is_move_first && q == 2'h1) begin
      next_mem.req = 1'b1;
      next_mem.addr = INSTR[11:0];
    end
    // second word: no dummy read, write only in the last quarter
    if (state == ST_MOVE_SECOND && q_end && is_move_second) begin
      next_mem.req = 1'b1;
      next_mem.wr = 1'b1;
      next_mem.addr = INSTR[11:0];
      next_mem.wdata = move_data;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mem <= '0;
    end else begin
      mem <= next_mem;
    end
  end

  // -----------------------------------------------------------------
  // status outputs
  // -----------------------------------------------------------------
  always_comb begin
    next_busy = (next_state != ST_FETCH);
    next_qphase = q;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      QPHASE <= Q_RESET;
      BUSY <= 1'b0;
    end else begin
      QPHASE <= next_qphase;
      BUSY <= next_busy;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all straight from registers
  // -----------------------------------------------------------------
  assign PC = pc;
  assign BANK_SELECT = bank;
  assign MEM = mem;
endmodule

// >>> tb/bmd_props.sv
// decoder checker
`timescale 1ns/1ns
module bmd_props
  import decode_pkg::*;
(input wire logic CLK,RST_N,OVERFLOW,ZERO,BUSY,input wire logic [15:0] INSTR,
 input wire logic [7:0] MEM_RDATA,BANK_SELECT,input wire logic [20:0] PC,
 input wire logic [1:0] QPHASE,input wire mem_req_type MEM);
  wire [7:0] o=INSTR[15:8],k=INSTR[7:0];
  wire [11:0] f=INSTR[11:0];
  wire q=QPHASE==2'h2&&!BUSY;
  wire m=!BUSY&&o[7:4]==4'hC;
  wire [20:0] n=PC+21'h2;
  wire [20:0] v=(o[2]?OVERFLOW:ZERO)?n:n+{{12{k[7]}},k,1'b0};
  default clocking @(posedge CLK);endclocking
  default disable iff(!RST_N);
  sequence s_w;(q&&m)##4(QPHASE==2'h2&&o[7:4]==4'hF);endsequence
  property p_ov;q&&o==8'hE5|=>PC==$past(v);endproperty
  property p_nz;q&&o==8'hE1|=>PC==$past(v);endproperty
  property p_id;q&&o==8'hE5&&!OVERFLOW|=>(BUSY&&!MEM.req)[*4]##1!BUSY;endproperty
  property p_rd;m&&QPHASE==2'h0&&$past(RST_N)|=>MEM.req&&MEM.addr==$past(f);endproperty
  property p_nr;BUSY|->!MEM.req;endproperty
  property p_wr;s_w|=>MEM.wr&&MEM.addr==$past(f);endproperty
  property p_dt;s_w|=>MEM.wdata==$past(MEM_RDATA,6);endproperty
  property p_bk;q&&o==8'h01|=>BANK_SELECT==$past(k)&&PC==$past(n);endproperty
  a_ov:assert property(p_ov)else $error("ov");
  a_nz:assert property(p_nz)else $error("nz");
  a_id:assert property(p_id)else $error("id");
  a_rd:assert property(p_rd)else $error("rd");
  a_nr:assert property(p_nr)else $error("nr");
  a_wr:assert property(p_wr)else $error("wr");
  a_dt:assert property(p_dt)else $error("dt");
  a_bk:assert property(p_bk)else $error("bk");
  c_w:cover property(s_w);
  c_q:cover property(q);
  c_b:cover property(BUSY);
endmodule
bind branch_move_decoder bmd_props bp(.CLK(CLK),.RST_N(RST_N),.OVERFLOW(OVERFLOW),.ZERO(ZERO),
  .BUSY(BUSY),.INSTR(INSTR),.MEM_RDATA(MEM_RDATA),.BANK_SELECT(BANK_SELECT),.PC(PC),
  .QPHASE(QPHASE),.MEM(MEM));

// >>> tb/tb_branch_move_decoder.sv
// decoder bench
`timescale 1ns/1ns
module tb_branch_move_decoder;
  import decode_pkg::*;
  logic CLK=0,RST_N=0,OVERFLOW=0,ZERO=0,BUSY;
  logic [15:0] INSTR=16'h0;
  logic [7:0] MEM_RDATA=8'h0,BANK_SELECT,k;
  logic [20:0] PC,p=21'h0;
  logic [1:0] QPHASE;
  logic [31:0] s=32'h87F3,r;
  mem_req_type MEM;
  int n_fail=0,num_checks=0,c=0;
  always #5 CLK=~CLK;
  branch_move_decoder branch_move_decoder_inst(.CLK(CLK),.RST_N(RST_N),.INSTR(INSTR),
    .OVERFLOW(OVERFLOW),.ZERO(ZERO),.MEM_RDATA(MEM_RDATA),.MEM(MEM),.PC(PC),
    .BANK_SELECT(BANK_SELECT),.QPHASE(QPHASE),.BUSY(BUSY));
  function automatic logic [31:0] rnd();
    s^=s<<13;
    s^=s>>17;
    s^=s<<5;
    return s;
  endfunction
  task automatic chk(input logic [63:0] g,e);
    num_checks++;
    if(g!==e) begin
      n_fail++;
      $display("CHECK FAILED %0t %h %h",$time,g,e);
    end
  endtask
  task automatic close_out();
    $display("%0d checks %0d fails",num_checks,n_fail);
    if(n_fail==0&&num_checks>0)$display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic run(input logic [15:0] w);
    INSTR=w;
    repeat(4)@(negedge CLK);
  endtask
  always @(posedge CLK) if(++c==4000) begin
    n_fail++;
    close_out();
  end
  initial begin
    repeat(3)@(negedge CLK);
    RST_N=1;
    repeat(300) begin
      r=rnd();
      k=r[13]?r[7:0]:{r[7],{7{!r[7]}}};
      {OVERFLOW,ZERO,MEM_RDATA}=r[31:22];
      p+=21'h2;
      case(r[11:10])
        2'h2: begin
          run({4'hC,r[21:10]});
          MEM_RDATA=~MEM_RDATA;
          run({4'hF,k,r[3:0]});
          chk(MEM,{2'h3,k,r[3:0],r[29:22]});
          p+=21'h2;
        end
        2'h3: begin
          run({8'h01,k});
          chk(BANK_SELECT,k);
        end
        default: begin
          run({4'hE,r[10]?4'h1:4'h5,k});
          if(!(r[10]?ZERO:OVERFLOW)) begin
            p+={{12{k[7]}},k,1'b0};
            chk({BUSY,PC},{1'b1,p});
            run(~INSTR);
          end
        end
      endcase
      chk({BUSY,PC},{1'b0,p});
      chk(QPHASE,2'h3);
    end
    close_out();
  end
endmodule
